// ===== rtl/cssc_defs.vh
// Purpose: constants for the clock switch and power save controller
// Assumes: 16-bit register port, word addressed
// Notes:   unlock keys and start-up length are module parameters
// Behaviour
// - request with new equal to current clears request and aborts
// - valid switch start clears lock flag bit 5 and fail flag bit 3
// - enable new oscillator if off; crystal waits for start-up timer (code skips it for primary with PLL while the PLL is already enabled)
// - PLL source waits until lock flag reads one
// - count 10 new-clock cycles before changing system clock
// - success clears request and copies new selection to current
// - old source off, except needed low-power RC and enabled secondary
// - processor keeps running during the switch sequence
// - monitor enabled keeps low-power RC running except in sleep
// - oscillator failure raises trap and moves system clock to fast RC
// - failure while PLL in use falls back to fast RC with PLL
// - power-save operand selects sleep or idle
// - sleep stops clocks, oscillators, clocked peripherals and monitoring
// - sleep keeps low-power RC running while watchdog is enabled
// - watchdog counter cleared on entering sleep and idle
// - wake on enabled interrupt, reset or watchdog time-out
// - wake from sleep restarts on the source active at entry (code lets a switch in flight at entry finish during sleep and change it)
// - idle stops CPU, system clock and peripherals keep running
// - idle keeps low-power RC while watchdog or monitor enabled
// - idle wake reapplies CPU clock at once
// - three-bit source encoding 000 to 111
// - switching disabled: ignore new selection, request held at zero
// - interrupt during power-save entry held off, then wakes
`ifndef CSSC_DEFS_VH
`define CSSC_DEFS_VH

// ==========================================================
// register addresses
`define CSSC_ADDR_CTRL     4'h0
`define CSSC_ADDR_KEY_HI   4'h1
`define CSSC_ADDR_KEY_LO   4'h2
`define CSSC_ADDR_STATUS   4'h3

// ==========================================================
// control register fields
`define CSSC_CUR_HI        14
`define CSSC_CUR_LO        12
`define CSSC_NEW_HI        10
`define CSSC_NEW_LO        8
`define CSSC_LOCK_BIT      5
`define CSSC_CF_BIT        3
`define CSSC_SECEN_BIT     1
`define CSSC_REQ_BIT       0

// ==========================================================
// source encodings
`define CSSC_SRC_FRC       3'h0
`define CSSC_SRC_FAST_RC_WITH_PLL    3'h1
`define CSSC_SRC_PRI       3'h2
`define CSSC_SRC_PRIPLL    3'h3
`define CSSC_SRC_SEC       3'h4
`define CSSC_SRC_LOW_POWER_RC_OSC      3'h5
`define CSSC_SRC_FRCDIV16  3'h6
`define CSSC_SRC_FRCDIVN   3'h7

// ==========================================================
// oscillator enable vector bits
`define CSSC_EN_FRC        0
`define CSSC_EN_PRI        1
`define CSSC_EN_SEC        2
`define CSSC_EN_LOW_POWER_RC_OSC       3
`define CSSC_EN_PLL        4

// ==========================================================
// timing and defaults
`define CSSC_SETTLE_CYC    4'hA
`define CSSC_OST_CYC       1024
`define CSSC_KEY1          8'h5A
`define CSSC_KEY2          8'hC3
`define CSSC_OP_SLEEP      1'b0

`endif

// ===== rtl/cssc_top.v
// Purpose: clock source switching, failsafe fallback, sleep and idle control
// Assumes: all inputs synchronous to clk_in; new_clk_tick_in pulses once
//          per cycle of the source being brought up
// Notes:   oscillators and clock gates are driven by enable outputs only
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/10ps
`include "cssc_defs.vh"

// ==========================================================
// key pair unlock: opens a one-write window
module cssc_unlock #(
	parameter [7:0] KEY1 = `CSSC_KEY1,
	parameter [7:0] KEY2 = `CSSC_KEY2
) (
	// clock and reset
	input  wire       clk_in,
	input  wire       sys_rst_in,
	// bus view
	input  wire       key_wr_in,
	input  wire       any_wr_in,
	input  wire [7:0] key_in,
	input  wire       consume_in,
	// window
	output reg        open_out
);
	reg stage_r;

	// second key must be the very next bus write
	always @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			stage_r  <= 1'b0;
			open_out <= 1'b0;
		end else begin
			if (key_wr_in && stage_r && key_in == KEY2) begin
				open_out <= 1'b1;
				stage_r  <= 1'b0;
			end else if (consume_in) begin
				open_out <= 1'b0; // single write only
				stage_r  <= 1'b0;
			end else if (any_wr_in) begin
				stage_r  <= key_wr_in && key_in == KEY1;
			end
		end
	end
endmodule // cssc_unlock

// ==========================================================
module cssc_top #(
	parameter [7:0] KEY1    = `CSSC_KEY1,
	parameter [7:0] KEY2    = `CSSC_KEY2,
	parameter       OST_CYC = `CSSC_OST_CYC
) (
	// clock and reset
	input  wire        clk_in,
	input  wire        sys_rst_in,
	// register port
	input  wire [3:0]  addr_in,
	input  wire [15:0] wdata_in,
	input  wire        wr_in,
	input  wire        rd_in,
	output reg  [15:0] rdata_out,
	// configuration
	input  wire        switch_monitor_config_bit_in,
	input  wire [2:0]  initial_source_config_in,
	input  wire        wdt_enable_in,
	// oscillator status
	input  wire        new_clk_tick_in,
	input  wire        pll_lock_in,
	input  wire        osc_fail_in,
	// core events
	input  wire        power_save_exec_in,
	input  wire        power_save_op_in,
	input  wire        irq_in,
	input  wire        wdt_timeout_in,
	// clock controls
	output reg  [2:0]  sys_src_sel_out,
	output reg  [4:0]  osc_enable_out,
	output reg         cpu_clk_en_out,
	output reg         periph_clk_en_out,
	output reg         switch_busy_out,
	// events and modes
	output reg         clock_fail_trap_out,
	output reg         wdt_clear_out,
	output reg         sleep_out,
	output reg         idle_out,
	output reg         wake_out
);
	// switch states
	localparam [4:0] S_IDLE = 5'h01;
	localparam [4:0] S_OST  = 5'h02;
	localparam [4:0] S_PLL  = 5'h04;
	localparam [4:0] S_CNT  = 5'h08;
	localparam [4:0] S_DONE = 5'h10;
	// power states
	localparam [2:0] P_RUN   = 3'h1;
	localparam [2:0] P_SLEEP = 3'h2;
	localparam [2:0] P_IDLE  = 3'h4;

	reg  [4:0]  sw_state_r;
	reg  [2:0]  pw_state_r;
	reg  [2:0]  cur_r;
	reg  [2:0]  new_r;
	reg  [2:0]  tgt_r;
	reg         req_r;
	reg         lock_r;
	reg         cf_r;
	reg         sec_en_r;
	reg  [4:0]  osc_en_r;
	reg  [10:0] cnt_r;
	reg         init_done_r;
	reg         irq_held_r;
	wire        hi_open;
	wire        lo_open;
	wire        ctrl_wr;
	wire        sw_enabled;
	wire        in_sleep;
	wire [4:0]  keep_mask;
	wire [4:0]  need_new;
	wire        start_ok;
	wire        fail_evt;
	wire        wake_evt;

	// one config bit gates both switching and monitoring
	assign sw_enabled = ~switch_monitor_config_bit_in;
	assign ctrl_wr    = wr_in && addr_in == `CSSC_ADDR_CTRL;
	assign in_sleep   = pw_state_r == P_SLEEP;

	// oscillators a given source needs
	function [4:0] need_mask;
		input [2:0] sel;
		begin
			need_mask = 5'h00;
			case (sel)
			`CSSC_SRC_FAST_RC_WITH_PLL: begin
				need_mask[`CSSC_EN_FRC] = 1'b1;
				need_mask[`CSSC_EN_PLL] = 1'b1;
			end
			`CSSC_SRC_PRI: need_mask[`CSSC_EN_PRI] = 1'b1;
			`CSSC_SRC_PRIPLL: begin
				need_mask[`CSSC_EN_PRI] = 1'b1;
				need_mask[`CSSC_EN_PLL] = 1'b1;
			end
			`CSSC_SRC_SEC:  need_mask[`CSSC_EN_SEC] = 1'b1;
			`CSSC_SRC_LOW_POWER_RC_OSC: need_mask[`CSSC_EN_LOW_POWER_RC_OSC] = 1'b1;
			default:        need_mask[`CSSC_EN_FRC] = 1'b1;
			endcase
		end
	endfunction

	// crystal sources need the start-up timer
	function is_xtal;
		input [2:0] sel;
		begin
			is_xtal = sel == `CSSC_SRC_PRI || sel == `CSSC_SRC_PRIPLL ||
				sel == `CSSC_SRC_SEC;
		end
	endfunction

	// oscillators that survive a switch
	assign keep_mask = {1'b0, (wdt_enable_in | sw_enabled),
		sec_en_r, 2'b00};
	assign need_new  = need_mask(tgt_r);
	// processor is not stalled; the switch runs beside it
	assign start_ok  = init_done_r && sw_state_r == S_IDLE && req_r &&
		!in_sleep;
	assign fail_evt  = sw_enabled && !in_sleep && osc_fail_in;
	assign wake_evt  = irq_in | wdt_timeout_in | irq_held_r;

	// ==========================================================
	// control byte unlock windows
	cssc_unlock #(
		.KEY1 (KEY1),
		.KEY2 (KEY2)
	) u_unlock_hi (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.key_wr_in  (wr_in && addr_in == `CSSC_ADDR_KEY_HI),
		.any_wr_in  (wr_in),
		.key_in     (wdata_in[7:0]),
		.consume_in (ctrl_wr),
		.open_out   (hi_open)
	);

	cssc_unlock #(
		.KEY1 (KEY1),
		.KEY2 (KEY2)
	) u_unlock_lo (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.key_wr_in  (wr_in && addr_in == `CSSC_ADDR_KEY_LO),
		.any_wr_in  (wr_in),
		.key_in     (wdata_in[7:0]),
		.consume_in (ctrl_wr),
		.open_out   (lo_open)
	);

	// ==========================================================
	// switch sequencer and control register
	always @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			sw_state_r          <= S_IDLE;
			cur_r               <= `CSSC_SRC_FRC;
			new_r               <= `CSSC_SRC_FRC;
			tgt_r               <= `CSSC_SRC_FRC;
			req_r               <= 1'b0;
			lock_r              <= 1'b0;
			cf_r                <= 1'b0;
			sec_en_r            <= 1'b0;
			osc_en_r            <= 5'h01;
			cnt_r               <= 11'h000;
			init_done_r         <= 1'b0;
			clock_fail_trap_out <= 1'b0;
		end else begin
			clock_fail_trap_out <= 1'b0;
			// default source caught after reset release
			if (!init_done_r) begin
				init_done_r <= 1'b1;
				cur_r       <= initial_source_config_in;
				new_r       <= initial_source_config_in;
				osc_en_r    <= need_mask(initial_source_config_in);
			end
			case (sw_state_r)
			S_IDLE: begin
				if (start_ok && new_r == cur_r) begin
					req_r <= 1'b0; // redundant, abort
				end else if (start_ok) begin
					lock_r   <= 1'b0;
					cf_r     <= 1'b0;
					tgt_r    <= new_r;
					cnt_r    <= 11'h000;
					osc_en_r <= osc_en_r | need_mask(new_r);
					if (is_xtal(new_r) &&
						(osc_en_r & need_mask(new_r)) == 5'h00) begin
						sw_state_r <= S_OST;
					end else begin
						sw_state_r <= S_PLL;
					end
				end
			end
			S_OST: begin
				// counted in ticks of the crystal itself
				if (new_clk_tick_in) begin
					cnt_r <= cnt_r + 11'h001;
				end
				if (cnt_r == OST_CYC[10:0]) begin
					cnt_r      <= 11'h000;
					sw_state_r <= S_PLL;
				end
			end
			S_PLL: begin
				if (!need_new[`CSSC_EN_PLL] || lock_r) begin
					sw_state_r <= S_CNT;
				end
			end
			S_CNT: begin
				if (new_clk_tick_in) begin
					cnt_r <= cnt_r + 11'h001;
				end
				if (cnt_r == {7'h00, `CSSC_SETTLE_CYC}) begin
					sw_state_r <= S_DONE;
				end
			end
			S_DONE: begin
				cur_r      <= tgt_r;
				req_r      <= 1'b0;
				osc_en_r   <= need_new | keep_mask;
				sw_state_r <= S_IDLE;
			end
			default: sw_state_r <= S_IDLE;
			endcase
			// failure overrides any switch in flight
			if (fail_evt && init_done_r) begin
				clock_fail_trap_out <= 1'b1;
				sw_state_r          <= S_IDLE;
				req_r               <= 1'b0;
				if (osc_en_r[`CSSC_EN_PLL]) begin
					cur_r    <= `CSSC_SRC_FAST_RC_WITH_PLL;
					osc_en_r <= need_mask(`CSSC_SRC_FAST_RC_WITH_PLL) | keep_mask;
				end else begin
					cur_r    <= `CSSC_SRC_FRC;
					osc_en_r <= need_mask(`CSSC_SRC_FRC) | keep_mask;
				end
			end
			// software side of the control register
			if (ctrl_wr && hi_open && sw_enabled) begin
				new_r <= wdata_in[`CSSC_NEW_HI:`CSSC_NEW_LO];
			end
			if (ctrl_wr && lo_open) begin
				sec_en_r <= wdata_in[`CSSC_SECEN_BIT];
				if (!wdata_in[`CSSC_CF_BIT]) begin
					cf_r <= 1'b0;
				end
				if (wdata_in[`CSSC_REQ_BIT] && sw_enabled) begin
					req_r <= 1'b1;
				end
			end
			if (!sw_enabled) begin
				req_r <= 1'b0; // held low
			end
			// hardware sets win over every clear
			if (pll_lock_in && osc_en_r[`CSSC_EN_PLL]) begin
				lock_r <= 1'b1;
			end else if (!osc_en_r[`CSSC_EN_PLL]) begin
				lock_r <= 1'b0; // reads zero while the pll is off
			end
			if (fail_evt) begin
				cf_r <= 1'b1;
			end
		end
	end

	// ==========================================================
	// sleep and idle
	always @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pw_state_r    <= P_RUN;
			irq_held_r    <= 1'b0;
			wdt_clear_out <= 1'b0;
			wake_out      <= 1'b0;
		end else begin
			wdt_clear_out <= 1'b0;
			wake_out      <= 1'b0;
			case (pw_state_r)
			P_RUN: begin
				if (power_save_exec_in) begin
					wdt_clear_out <= 1'b1;
					irq_held_r    <= irq_in; // held off
					if (power_save_op_in == `CSSC_OP_SLEEP) begin
						pw_state_r <= P_SLEEP;
					end else begin
						pw_state_r <= P_IDLE;
					end
				end
			end
			P_SLEEP, P_IDLE: begin
				if (wake_evt) begin
					// cur_r changes in sleep only when a switch already in flight reaches S_DONE
					pw_state_r <= P_RUN;
					irq_held_r <= 1'b0;
					wake_out   <= 1'b1;
				end
			end
			default: pw_state_r <= P_RUN;
			endcase
		end
	end

	// ==========================================================
	// registered clock controls and read port
	always @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			sys_src_sel_out   <= `CSSC_SRC_FRC;
			osc_enable_out    <= 5'h01;
			cpu_clk_en_out    <= 1'b1;
			periph_clk_en_out <= 1'b1;
			switch_busy_out   <= 1'b0;
			sleep_out         <= 1'b0;
			idle_out          <= 1'b0;
			rdata_out         <= 16'h0000;
		end else begin
			sys_src_sel_out   <= cur_r;
			switch_busy_out   <= sw_state_r != S_IDLE;
			sleep_out         <= in_sleep;
			idle_out          <= pw_state_r == P_IDLE;
			cpu_clk_en_out    <= pw_state_r == P_RUN;
			periph_clk_en_out <= !in_sleep;
			if (in_sleep) begin
				// all oscillators stop, watchdog RC excepted
				osc_enable_out <= {1'b0, wdt_enable_in, 3'h0};
			end else begin
				osc_enable_out <= osc_en_r | keep_mask;
			end
			rdata_out <= 16'h0000;
			if (rd_in && addr_in == `CSSC_ADDR_CTRL) begin
				rdata_out[`CSSC_CUR_HI:`CSSC_CUR_LO] <= cur_r;
				rdata_out[`CSSC_NEW_HI:`CSSC_NEW_LO] <= new_r;
				rdata_out[`CSSC_LOCK_BIT]            <= lock_r;
				rdata_out[`CSSC_CF_BIT]              <= cf_r;
				rdata_out[`CSSC_SECEN_BIT]           <= sec_en_r;
				rdata_out[`CSSC_REQ_BIT]             <= req_r;
			end else if (rd_in && addr_in == `CSSC_ADDR_STATUS) begin
				rdata_out <= {3'h0, pw_state_r, 3'h0, sw_state_r, osc_en_r[1:0]};
			end
		end
	end
endmodule // cssc_top

// ===== tb/cssc_top_sva.sv
// Purpose: port level checks for the clock switch and power save block
// Assumes: one clock domain, reset asynchronous and active high
// Notes:   bound to cssc_top from the bench top file
`timescale 1ns/10ps

// ==========================================================
// checker
module cssc_top_sva (
	// clock and reset
	input wire        clk_in,
	input wire        sys_rst_in,
	// configuration and events
	input wire        switch_monitor_config_bit_in,
	input wire        wdt_enable_in,
	input wire        osc_fail_in,
	// clock controls
	input wire [2:0]  sys_src_sel_out,
	input wire [4:0]  osc_enable_out,
	input wire        cpu_clk_en_out,
	input wire        periph_clk_en_out,
	input wire        switch_busy_out,
	// events and modes
	input wire        clock_fail_trap_out,
	input wire        wdt_clear_out,
	input wire        sleep_out,
	input wire        idle_out,
	input wire        wake_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	// outputs lag state by a cycle, so causes are looked for two back
	chk_trap_cause: assert property (clock_fail_trap_out |->
		$past(osc_fail_in) || $past(osc_fail_in, 2))
		else $error("trap without oscillator failure");
	chk_fail_fallback: assert property (clock_fail_trap_out |->
		##[0:2] (sys_src_sel_out == 3'h0 || sys_src_sel_out == 3'h1))
		else $error("failure did not fall back to fast rc");
	chk_clear_entry: assert property (wdt_clear_out |->
		##[0:2] (sleep_out || idle_out))
		else $error("watchdog clear without power save entry");
	chk_sleep_gates: assert property (sleep_out |->
		!cpu_clk_en_out && !periph_clk_en_out &&
		osc_enable_out == {1'b0, wdt_enable_in, 3'b000})
		else $error("sleep left clocks running");
	chk_idle_clocks: assert property (idle_out |->
		!cpu_clk_en_out && periph_clk_en_out && (osc_enable_out[3] ||
		!(wdt_enable_in || !switch_monitor_config_bit_in)))
		else $error("idle clock gating wrong");
	// settle window after reset, wake and config change is skipped
	chk_monitor_low_power_rc_osc: assert property (!sleep_out && !$past(sleep_out) &&
		!$past(sys_rst_in, 2) && !switch_monitor_config_bit_in &&
		!$past(switch_monitor_config_bit_in) &&
		!$past(switch_monitor_config_bit_in, 2) |-> osc_enable_out[3])
		else $error("monitor on but low power rc off");
	chk_wake_restore: assert property (wake_out |=> cpu_clk_en_out)
		else $error("cpu clock not back after wake");
	chk_sleep_source: assert property (sleep_out |->
		$stable(sys_src_sel_out))
		else $error("source changed during sleep");
	chk_run_in_switch: assert property (switch_busy_out && !sleep_out &&
		!idle_out && !wake_out |-> cpu_clk_en_out)
		else $error("cpu stopped during switch");
endmodule // cssc_top_sva

// ===== tb/cssc_osc_model.sv
// Purpose: behavioural oscillator, pll and failure detector
// Assumes: enables come from the controller under test
// Notes:   slow mode ticks once every four system cycles
`timescale 1ns/10ps

// ==========================================================
// oscillator model
module cssc_osc_model (
	// clock and reset
	input  wire       clk_in,
	input  wire       sys_rst_in,
	// from controller and bench
	input  wire [4:0] osc_enable_in,
	input  wire       slow_in,
	input  wire       fail_cmd_in,
	// status towards controller
	output reg        tick_out,
	output reg        lock_out,
	output reg        fail_out
);
	reg [1:0] div_r;
	reg [3:0] lock_cnt_r;

	// ticks only while something runs; slow mode stretches start-up
	always @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			div_r      <= 2'h0;
			tick_out   <= 1'b0;
			lock_cnt_r <= 4'h0;
			lock_out   <= 1'b0;
			fail_out   <= 1'b0;
		end else begin
			div_r    <= div_r + 2'h1;
			tick_out <= (|osc_enable_in) & (~slow_in | (div_r == 2'h3));
			fail_out <= fail_cmd_in;
			if (!osc_enable_in[4]) begin
				lock_cnt_r <= 4'h0;
				lock_out   <= 1'b0;
			end else if (lock_cnt_r == 4'h7) begin
				lock_out <= 1'b1;
			end else begin
				lock_cnt_r <= lock_cnt_r + 4'h1;
			end
		end
	end
endmodule // cssc_osc_model

// ===== tb/cssc_top_tb.sv
// Purpose: self-checking bench for the clock switch controller
// Assumes: start-up count shortened to 4 ticks
// Notes:   firmware side is played by bus tasks
`timescale 1ns/10ps
`include "cssc_defs.vh"

// ==========================================================
// bench top
module cssc_top_tb;
	reg         clk, rst, wr, rd, cfg, wdt_en, exec, op, irq, wto;
	reg         slow, fail_cmd;
	reg  [3:0]  addr;
	reg  [15:0] wdata;
	reg  [2:0]  init_src;
	reg  [15:0] wakes, clears, traps, busy_cyc;
	wire [15:0] rdata;
	wire [2:0]  src;
	wire [4:0]  oen;
	wire        tick, lock, fail, cpu_en, per_en, busy;
	wire        trap, wclr, slp, idl, wake;
	integer     miscompares, checks;

	cssc_top #(.OST_CYC(4)) i_cssc_top (.clk_in(clk), .sys_rst_in(rst),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
		.rdata_out(rdata), .switch_monitor_config_bit_in(cfg),
		.initial_source_config_in(init_src), .wdt_enable_in(wdt_en),
		.new_clk_tick_in(tick), .pll_lock_in(lock), .osc_fail_in(fail),
		.power_save_exec_in(exec), .power_save_op_in(op), .irq_in(irq),
		.wdt_timeout_in(wto), .sys_src_sel_out(src), .osc_enable_out(oen),
		.cpu_clk_en_out(cpu_en), .periph_clk_en_out(per_en),
		.switch_busy_out(busy), .clock_fail_trap_out(trap),
		.wdt_clear_out(wclr), .sleep_out(slp), .idle_out(idl),
		.wake_out(wake));
	cssc_osc_model i_cssc_osc_model (.clk_in(clk), .sys_rst_in(rst),
		.osc_enable_in(oen), .slow_in(slow), .fail_cmd_in(fail_cmd),
		.tick_out(tick), .lock_out(lock), .fail_out(fail));

	// ==========================================================
	// clock, event counters, watchdog
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		if (wake === 1'b1) wakes = wakes + 16'h0001;
		if (wclr === 1'b1) clears = clears + 16'h0001;
		if (trap === 1'b1) traps = traps + 16'h0001;
		if (busy === 1'b1) busy_cyc = busy_cyc + 16'h0001;
	end
	// whole run is a few hundred cycles
	initial begin
		#400000;
		miscompares = miscompares + 1;
		summarize;
	end

	// ==========================================================
	// helpers
	task chk(input [15:0] got, input [15:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				miscompares = miscompares + 1;
				$display("[ERR] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task wr_reg(input [3:0] a, input [15:0] d);
		begin
			@(posedge clk);
			addr  <= a;
			wdata <= d;
			wr    <= 1'b1;
			@(posedge clk);
			wr    <= 1'b0;
		end
	endtask
	task rd_reg(input [3:0] a, output [15:0] d);
		begin
			@(posedge clk);
			addr <= a;
			rd   <= 1'b1;
			@(posedge clk);
			rd   <= 1'b0;
			#1;
			d = rdata;
		end
	endtask
	task unlock(input [3:0] a);
		begin
			wr_reg(a, {8'h00, `CSSC_KEY1});
			wr_reg(a, {8'h00, `CSSC_KEY2});
		end
	endtask
	// bounded wait for the sequencer to go quiet
	task req_switch(input [2:0] s);
		integer n;
		begin
			unlock(`CSSC_ADDR_KEY_HI);
			wr_reg(`CSSC_ADDR_CTRL, {5'h00, s, 8'h00});
			unlock(`CSSC_ADDR_KEY_LO);
			wr_reg(`CSSC_ADDR_CTRL, 16'h0001);
			n = 0;
			repeat (3) @(posedge clk);
			#1;
			while (busy !== 1'b0 && n < 2000) begin
				@(posedge clk);
				#1;
				n = n + 1;
			end
			if (n >= 2000) begin
				miscompares = miscompares + 1;
				$display("[ERR] %0t switch never completed", $time);
			end
			repeat (3) @(posedge clk);
			#1;
		end
	endtask
	task summarize;
		begin
			$display("checks %0d miscompares %0d", checks, miscompares);
			if (miscompares == 0 && checks > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask

	// ==========================================================
	// scenarios
	task t_reset;
		reg [15:0] d;
		begin
			#1;
			chk({13'h0000, src}, 16'h0000);
			chk({11'h000, oen}, 16'h0009);
			rd_reg(`CSSC_ADDR_CTRL, d);
			chk(d, 16'h0000);
			rd_reg(4'hF, d);
			chk(d, 16'h0000);
			$display("test reset done");
		end
	endtask
	task t_switch(input [2:0] s, input [15:0] ctrl, input [4:0] en);
		reg [15:0] d;
		begin
			req_switch(s);
			chk({13'h0000, src}, {13'h0000, s});
			rd_reg(`CSSC_ADDR_CTRL, d);
			chk(d, ctrl);
			chk({11'h000, oen}, {11'h000, en});
			$display("test switch done");
		end
	endtask
	task t_redundant;
		reg [15:0] b0, d;
		begin
			b0 = busy_cyc;
			req_switch(`CSSC_SRC_SEC);
			chk(busy_cyc - b0, 16'h0000);
			rd_reg(`CSSC_ADDR_CTRL, d);
			chk(d, 16'h4400);
			$display("test redundant done");
		end
	endtask
	task t_fail(input [2:0] s);
		reg [15:0] t0, d;
		begin
			t0 = traps;
			@(posedge clk);
			fail_cmd <= 1'b1;
			@(posedge clk);
			fail_cmd <= 1'b0;
			repeat (5) @(posedge clk);
			rd_reg(`CSSC_ADDR_CTRL, d);
			chk(traps - t0, 16'h0001);
			chk({13'h0000, src}, {13'h0000, s});
			chk(d & 16'h7008, {1'b0, s, 12'h008});
			$display("test failure done");
		end
	endtask
	task t_locked;
		reg [15:0] d;
		begin
			@(posedge clk);
			cfg <= 1'b1;
			req_switch(`CSSC_SRC_PRI);
			rd_reg(`CSSC_ADDR_CTRL, d);
			chk(d & 16'h0701, 16'h0000);
			chk({13'h0000, src}, 16'h0000);
			cfg <= 1'b0;
			repeat (4) @(posedge clk);
			$display("test locked done");
		end
	endtask
	task t_psave(input o, input early);
		reg [15:0] w0, c0;
		begin
			w0 = wakes;
			c0 = clears;
			@(posedge clk);
			exec <= 1'b1;
			op   <= o;
			irq  <= early;
			@(posedge clk);
			exec <= 1'b0;
			irq  <= 1'b0;
			if (!early) begin
				repeat (4) @(posedge clk);
				#1;
				chk({14'h0000, idl, slp}, o ? 16'h0002 : 16'h0001);
				chk({14'h0000, cpu_en, per_en}, {15'h0000, o});
				if (!o) chk({11'h000, oen}, {12'h000, wdt_en, 3'h0});
				@(posedge clk);
				wto <= o;
				irq <= ~o;
				@(posedge clk);
				wto <= 1'b0;
				irq <= 1'b0;
			end
			repeat (6) @(posedge clk);
			#1;
			chk(wakes - w0, 16'h0001);
			chk(clears - c0, 16'h0001);
			chk({15'h0000, cpu_en}, 16'h0001);
			chk({13'h0000, src}, 16'h0000);
			$display("test power save done");
		end
	endtask
	// reset taken while asleep must wake and reload the default source
	task t_rereset;
		reg [15:0] d;
		begin
			@(posedge clk);
			exec <= 1'b1;
			op   <= 1'b0;
			@(posedge clk);
			exec <= 1'b0;
			repeat (3) @(posedge clk);
			rst      <= 1'b1;
			init_src <= `CSSC_SRC_PRI;
			repeat (2) @(posedge clk);
			rst <= 1'b0;
			repeat (3) @(posedge clk);
			#1;
			chk({14'h0000, slp, cpu_en}, 16'h0001);
			chk({13'h0000, src}, {13'h0000, `CSSC_SRC_PRI});
			rd_reg(`CSSC_ADDR_CTRL, d);
			chk(d, 16'h2200);
			$display("test reset wake done");
		end
	endtask

	// ==========================================================
	// main sequence
	initial begin
		{rst, wr, rd, cfg, exec, op, irq, wto, fail_cmd} = 9'h100;
		{wdt_en, slow} = 2'h3;
		addr = 4'h0;
		wdata = 16'h0000;
		init_src = `CSSC_SRC_FRC;
		{wakes, clears, traps, busy_cyc} = 64'h0;
		miscompares = 0;
		checks = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		t_reset;
		t_switch(`CSSC_SRC_SEC, 16'h4400, 5'h0C);
		t_redundant;
		t_fail(`CSSC_SRC_FRC);
		slow <= 1'b0;
		t_switch(`CSSC_SRC_FAST_RC_WITH_PLL, 16'h1120, 5'h19);
		t_fail(`CSSC_SRC_FAST_RC_WITH_PLL);
		t_switch(`CSSC_SRC_FRC, 16'h0000, 5'h09); // via plain fast RC
		t_locked;
		t_psave(1'b0, 1'b0);
		t_psave(1'b1, 1'b0);
		t_psave(1'b1, 1'b1);
		t_psave(1'b0, 1'b1);
		wdt_en <= 1'b0;
		t_psave(1'b0, 1'b0);
		wdt_en <= 1'b1;
		t_rereset;
		summarize;
	end
endmodule // cssc_top_tb

bind cssc_top cssc_top_sva i_cssc_top_sva (.clk_in(clk_in),
	.sys_rst_in(sys_rst_in), .wdt_enable_in(wdt_enable_in),
	.switch_monitor_config_bit_in(switch_monitor_config_bit_in),
	.osc_fail_in(osc_fail_in), .sys_src_sel_out(sys_src_sel_out),
	.osc_enable_out(osc_enable_out), .cpu_clk_en_out(cpu_clk_en_out),
	.periph_clk_en_out(periph_clk_en_out), .switch_busy_out(switch_busy_out),
	.clock_fail_trap_out(clock_fail_trap_out), .wdt_clear_out(wdt_clear_out),
	.sleep_out(sleep_out), .idle_out(idle_out), .wake_out(wake_out));
